// ---- rtl/debug_clock_frequency_counter.sv ----
`timescale 1ns/1ns
// Summary of operation
// - Four debug clock inputs; each request selects exactly one to measure.
// - Selected clock is measured over a 1 ms gate, then frequency reported.
// - No clock activity during the gate reports the result as not valid.
// - Results are flagged in range from 2 kHz to 333.33 MHz; inputs above 50 MHz alias.
module debug_clock_frequency_counter
    import freq_counter_pkg::*;
#(
    parameter int GATE_COUNT = GATE_CYCLES
)
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [NUM_DEBUG_CLOCKS-1:0] debug_clock_inputs,
    input wire logic meas_request,
    input wire logic [SEL_WIDTH-1:0] meas_select,
    output logic meas_busy_r,
    output logic meas_done_r,
    output logic freq_valid_r,
    output logic in_range_r,
    output logic [FREQ_WIDTH-1:0] freq_hz_r
);

    logic rst_sync1_r;
    logic rst_sync_b_r;
    logic [NUM_DEBUG_CLOCKS-1:0] dbg_sync1_r;
    logic [NUM_DEBUG_CLOCKS-1:0] dbg_sync2_r;
    logic dbg_prev_r;
    logic [SEL_WIDTH-1:0] sel_r;
    meas_state_e state_r;
    // Timer just wide enough to reach the gate count
    localparam int GATE_CNT_WIDTH = $clog2(GATE_COUNT + 1);
    logic [GATE_CNT_WIDTH-1:0] gate_cnt_r;
    logic [EDGE_CNT_WIDTH-1:0] edge_cnt_r;
    logic [FREQ_WIDTH-1:0] freq_calc;
    logic rise;
    logic sel_level;
    logic in_idle;
    logic in_settle;
    logic in_gate;
    logic in_report;
    logic take_request;
    logic gate_last;

    // Edges per gate times gates per second gives hertz
    function automatic logic [FREQ_WIDTH-1:0] edges_to_hz(input logic [EDGE_CNT_WIDTH-1:0] edges);
        logic [FREQ_WIDTH-1:0] wide;
        wide = FREQ_WIDTH'(edges);
        return wide * FREQ_WIDTH'(GATES_PER_SECOND);
    endfunction : edges_to_hz

    // Span over which a result can be trusted
    function automatic logic within_span(input logic [FREQ_WIDTH-1:0] hz);
        logic above_floor;
        logic below_ceiling;
        above_floor = (hz >= FREQ_WIDTH'(MIN_FREQ_HZ));
        below_ceiling = (hz <= FREQ_WIDTH'(MAX_FREQ_HZ));
        return above_floor && below_ceiling;
    endfunction : within_span

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rst_sync1_r <= 1'b0;
            rst_sync_b_r <= 1'b0;
        end
        else
        begin
            rst_sync1_r <= 1'b1;
            rst_sync_b_r <= rst_sync1_r;
        end
    end

    // Debug clocks are asynchronous: two-stage sample before use
    always_ff @(posedge clk or negedge rst_sync_b_r)
    begin
        if (!rst_sync_b_r)
        begin
            dbg_sync1_r <= '0;
            dbg_sync2_r <= '0;
        end
        else
        begin
            dbg_sync1_r <= debug_clock_inputs;
            dbg_sync2_r <= dbg_sync1_r;
        end
    end

    always_ff @(posedge clk or negedge rst_sync_b_r)
    begin
        if (!rst_sync_b_r)
            dbg_prev_r <= 1'b0;
        else
            dbg_prev_r <= sel_level;
    end

    assign sel_level = dbg_sync2_r[sel_r];
    assign rise = sel_level && !dbg_prev_r;

    // State decodes shared by several processes
    assign in_idle = (state_r == ST_IDLE);
    assign in_settle = (state_r == ST_SETTLE);
    assign in_gate = (state_r == ST_GATE);
    assign in_report = (state_r == ST_REPORT);
    // Requests are taken only while idle; others are dropped silently
    assign take_request = in_idle && meas_request;
    assign gate_last = (gate_cnt_r == GATE_CNT_WIDTH'(GATE_COUNT - 1));

    always_ff @(posedge clk or negedge rst_sync_b_r)
    begin
        if (!rst_sync_b_r)
        begin
            state_r <= ST_IDLE;
        end
        else
        begin
            unique case (state_r)
                ST_IDLE:
                begin
                    if (take_request)
                        state_r <= ST_SETTLE;
                end
                ST_SETTLE:
                begin
                    // One cycle to let the edge history follow the new select
                    state_r <= ST_GATE;
                end
                ST_GATE:
                begin
                    if (gate_last)
                        state_r <= ST_REPORT;
                end
                ST_REPORT:
                    state_r <= ST_IDLE;
            endcase
        end
    end

    // Select is frozen for the whole measurement
    always_ff @(posedge clk or negedge rst_sync_b_r)
    begin
        if (!rst_sync_b_r)
            sel_r <= '0;
        else if (take_request)
            sel_r <= meas_select;
    end

    // Reference timer holding the gate open
    always_ff @(posedge clk or negedge rst_sync_b_r)
    begin
        if (!rst_sync_b_r)
            gate_cnt_r <= '0;
        else if (in_settle)
            gate_cnt_r <= '0;
        else if (in_gate && !gate_last)
            gate_cnt_r <= gate_cnt_r + {{(GATE_CNT_WIDTH-1){1'b0}}, 1'b1};
    end

    // Saturates rather than wrapping on a runaway input
    always_ff @(posedge clk or negedge rst_sync_b_r)
    begin
        if (!rst_sync_b_r)
            edge_cnt_r <= '0;
        else if (in_settle)
            edge_cnt_r <= '0;
        else if (in_gate && rise && !(&edge_cnt_r))
            edge_cnt_r <= edge_cnt_r + {{(EDGE_CNT_WIDTH-1){1'b0}}, 1'b1};
    end

    // Saturated count times gates per second still fits the result width
    assign freq_calc = edges_to_hz(edge_cnt_r);

    // Busy from the cycle after a taken request to the done pulse
    always_ff @(posedge clk or negedge rst_sync_b_r)
    begin
        if (!rst_sync_b_r)
            meas_busy_r <= 1'b0;
        else if (take_request)
            meas_busy_r <= 1'b1;
        else if (in_report)
            meas_busy_r <= 1'b0;
    end

    // Single-cycle pulse as the results land
    always_ff @(posedge clk or negedge rst_sync_b_r)
    begin
        if (!rst_sync_b_r)
            meas_done_r <= 1'b0;
        else
            meas_done_r <= in_report;
    end

    // Results hold until the next measurement ends
    always_ff @(posedge clk or negedge rst_sync_b_r)
    begin
        if (!rst_sync_b_r)
            freq_hz_r <= '0;
        else if (in_report)
            freq_hz_r <= freq_calc;
    end

    // No rising edge during the gate marks the result unusable
    always_ff @(posedge clk or negedge rst_sync_b_r)
    begin
        if (!rst_sync_b_r)
            freq_valid_r <= 1'b0;
        else if (in_report)
            freq_valid_r <= (edge_cnt_r != '0);
    end

    // Trust flag for the measured value
    // Inputs above half the reference rate alias, so the flag only judges the count
    always_ff @(posedge clk or negedge rst_sync_b_r)
    begin
        if (!rst_sync_b_r)
            in_range_r <= 1'b0;
        else if (in_report)
            in_range_r <= within_span(freq_calc);
    end

endmodule : debug_clock_frequency_counter

// ---- include/freq_counter_pkg.sv ----
package freq_counter_pkg;

    localparam int CLK_FREQ_HZ = 100_000_000;
    localparam int NUM_DEBUG_CLOCKS = 4;
    localparam int SEL_WIDTH = 2;
    // Gate time in microseconds
    localparam int GATE_TIME_US = 1000;
    localparam int GATE_CYCLES = (CLK_FREQ_HZ / 1_000_000) * GATE_TIME_US;
    // Input span in hertz judged by the range flag
    localparam int MIN_FREQ_HZ = 2000;
    localparam int MAX_FREQ_HZ = 333_330_000;
    localparam int GATES_PER_SECOND = 1_000_000 / GATE_TIME_US;
    localparam int EDGE_CNT_WIDTH = 20;
    localparam int FREQ_WIDTH = 32;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SETTLE = 2'b01,
        ST_GATE = 2'b11,
        ST_REPORT = 2'b10
    } meas_state_e;

endpackage : freq_counter_pkg

// ---- tb/freq_counter_asserts.sv ----
`timescale 1ns/1ns
module freq_counter_asserts
    import freq_counter_pkg::*;
#(
    parameter int GATE_COUNT = GATE_CYCLES
)
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic meas_request,
    input wire logic meas_busy_r,
    input wire logic meas_done_r,
    input wire logic freq_valid_r,
    input wire logic in_range_r,
    input wire logic [FREQ_WIDTH-1:0] freq_hz_r
);
    localparam int LAT = GATE_COUNT + 3;
    int unsigned since_take;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // Cycles since a request was taken, zero while none is open
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            since_take <= 0;
        else if (meas_request && !meas_busy_r)
            since_take <= 1;
        else if (meas_done_r)
            since_take <= 0;
        else if (since_take != 0)
            since_take <= since_take + 1;
    end
    AST_LATENCY: assert property (since_take == LAT |-> meas_done_r)
        else $error("done late");
    AST_EARLY: assert property (meas_done_r |-> since_take == LAT)
        else $error("done at wrong time");
    AST_PULSE: assert property (meas_done_r |-> !meas_busy_r ##1 !meas_done_r)
        else $error("done too long");
    AST_BUSY: assert property (meas_request && !meas_busy_r |=> meas_busy_r && !meas_done_r)
        else $error("request not taken");
    AST_VALID: assert property (meas_done_r |-> freq_valid_r == (freq_hz_r != 0))
        else $error("bad valid");
    AST_SPAN: assert property (meas_done_r |->
        in_range_r == (freq_hz_r >= MIN_FREQ_HZ && freq_hz_r <= MAX_FREQ_HZ)) else $error("bad span");
    cover property (meas_done_r && !freq_valid_r);
    cover property (meas_done_r && in_range_r);
    cover property (meas_request && meas_busy_r);
endmodule : freq_counter_asserts

// ---- tb/debug_clock_source.sv ----
`timescale 1ns/1ns
module debug_clock_source
(
    output logic [3:0] dclk
);
    logic dclk1 = 1'b0;
    logic dclk2 = 1'b0;
    logic dclk3 = 1'b0;
    // Clock 0 stays still as a missing clock; no edge meets a reference rising edge
    always #20 dclk1 = ~dclk1;
    always #50 dclk2 = ~dclk2;
    always #130 dclk3 = ~dclk3;
    assign dclk = {dclk3, dclk2, dclk1, 1'b0};
endmodule : debug_clock_source

// ---- tb/test_debug_clock_frequency_counter.sv ----
`timescale 1ns/1ns
module test_debug_clock_frequency_counter;
    import freq_counter_pkg::*;
    localparam int GATE = 100;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic meas_request = 1'b0;
    logic [1:0] meas_select = 2'h0;
    logic [3:0] dclk;
    logic meas_busy_r, meas_done_r, freq_valid_r, in_range_r;
    logic [31:0] freq_hz_r;
    int mismatches = 0;
    int check_count = 0;
    always #5 clk = ~clk;
    debug_clock_source src (.dclk(dclk));
    debug_clock_frequency_counter #(.GATE_COUNT(GATE)) uut (.clk(clk), .rst_b(rst_b), .debug_clock_inputs(dclk),
        .meas_request(meas_request), .meas_select(meas_select), .meas_busy_r(meas_busy_r),
        .meas_done_r(meas_done_r), .freq_valid_r(freq_valid_r), .in_range_r(in_range_r), .freq_hz_r(freq_hz_r));
    task automatic check(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
        check_count++;
        if ((got >= lo && got <= hi) !== 1'b1)
        begin
            mismatches++;
            $display("mismatch %0t got %h expected %h..%h", $time, got, lo, hi);
        end
    endtask : check
    // Second request while busy carries another select and must be ignored
    task automatic measure(input logic [1:0] s, input int lo, input int hi, input logic poke);
        int n;
        @(negedge clk);
        meas_request = 1'b1;
        meas_select = s;
        @(negedge clk);
        meas_request = poke;
        meas_select = ~s;
        n = 1;
        while (meas_done_r !== 1'b1 && n < 300)
        begin
            @(negedge clk);
            meas_request = 1'b0;
            n++;
        end
        check(n, GATE + 3, GATE + 3);
        check(freq_hz_r, lo, hi);
        check(freq_valid_r, hi != 0, hi != 0);
        check(in_range_r, lo >= MIN_FREQ_HZ, lo >= MIN_FREQ_HZ);
        $display("test on clock %0d done", s);
    endtask : measure
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : conclude
    initial
    begin
        repeat (3) @(negedge clk);
        rst_b = 1'b1;
        repeat (3) @(negedge clk);
        measure(2'h0, 0, 0, 1'b0);
        measure(2'h1, 24000, 26000, 1'b1);
        measure(2'h2, 9000, 11000, 1'b0);
        measure(2'h3, 3000, 5000, 1'b0);
        conclude();
    end
    initial
    begin
        #100000;
        mismatches++;
        conclude();
    end
endmodule : test_debug_clock_frequency_counter
bind debug_clock_frequency_counter freq_counter_asserts #(.GATE_COUNT(GATE_COUNT)) chk (.clk(clk), .rst_b(rst_b),
    .meas_request(meas_request), .meas_busy_r(meas_busy_r), .meas_done_r(meas_done_r),
    .freq_valid_r(freq_valid_r), .in_range_r(in_range_r), .freq_hz_r(freq_hz_r));
